// ==== rtl/rx_status_pkg.sv ====
/*
 receive frame status reporting: register map, field positions, reset
 values and shared types. assumes a single 125 MHz clock domain.
*/
//
// Contract
// - status register mirrors the status word stored with the head queued frame.
// - bit 15 set only when the head frame is complete and its status valid.
// - bit 15 clear when no finished frame is queued, whether or not one is arriving.
// - bit 7 set for a broadcast destination address.
// - bit 6 set for any multicast destination, broadcast included.
// - bit 5 set for a unicast destination address.
// - bit 4 set when a symbol error was seen during the frame.
// - bit 3 set when length/type exceeds 1500, clear otherwise.
// - bit 2 set when the frame is longer than 1916 bytes.
// - over-length frames are kept only when pass-bad (control bit 9) is set.
// - over-length frames are never cut; the flag only reports length.
// - bit 1 set for a collision-damaged or prematurely ended frame.
// - runt frames are kept only when pass-bad is set.
// - bit 0 set when the frame check sequence is wrong.
// - frames with a bad check sequence are kept only when pass-bad is set.
// - byte count register mirrors the count word stored with the head frame.
// - byte count sits in bits 10 to 0 of the byte count register.
package rx_status_pkg;

	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_CONTROL    = 6'h00;
	localparam logic [5:0] IDX_RELEASE    = 6'h01;
	localparam logic [5:0] IDX_STATUS     = 6'h04;
	localparam logic [5:0] IDX_BYTE_COUNT = 6'h06;

	// status word field positions
	localparam int FV_BIT   = 15;
	localparam int BC_BIT   = 7;
	localparam int MC_BIT   = 6;
	localparam int UC_BIT   = 5;
	localparam int SYM_BIT  = 4;
	localparam int TYPE_BIT = 3;
	localparam int LONG_BIT = 2;
	localparam int RUNT_BIT = 1;
	localparam int FCS_BIT  = 0;

	// control and release register field positions
	localparam int CTRL_FULL_BIT   = 0;
	localparam int CTRL_OVF_BIT    = 1;
	localparam int CTRL_BUSY_BIT   = 2;
	localparam int CTRL_PASS_BIT   = 9;
	localparam int RELEASE_POP_BIT = 0;

	// reset values
	localparam logic PASS_BAD_RESET = 1'b0;

	// widths and limits
	localparam int STATUS_W     = 16;
	localparam int BYTE_COUNT_W = 11;
	localparam int QUEUE_DEPTH  = 4;
	localparam logic [15:0] TYPE_THRESHOLD = 16'h05dc;
	localparam logic [10:0] MAX_FRAME_BYTES = 11'h77c;

	// one queued frame: status word and byte count word
	typedef struct packed {
		logic [STATUS_W-1:0]     status;
		logic [BYTE_COUNT_W-1:0] count;
	} entry_s;

	// register bus handshake states
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK  = 2'b10
	} bus_state_e;

endpackage : rx_status_pkg

// ==== rtl/rx_queue_if.sv ====
/*
 carrier between the status reporter and its frame status queue.
 assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface rx_queue_if;
	import rx_status_pkg::*;

	logic   push;
	entry_s push_entry;
	logic   pop;
	entry_s head;
	logic   empty;
	logic   full;

	modport owner (output push, output push_entry, output pop,
		input head, input empty, input full);
	modport store (input push, input push_entry, input pop,
		output head, output empty, output full);
endinterface : rx_queue_if
`default_nettype wire

// ==== rtl/rx_status_queue.sv ====
/*
 receive queue of completed frame status words, head first.
 assumes the owner never pushes when full nor pops when empty.
*/
`timescale 1ns/100ps
`default_nettype none
module rx_status_queue #(
	parameter int DEPTH = rx_status_pkg::QUEUE_DEPTH
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// owner side
	rx_queue_if.store q
);
	import rx_status_pkg::*;

	localparam int PW = $clog2(DEPTH);

	entry_s           mem [DEPTH];
	logic   [PW-1:0]  rd_ptr;
	logic   [PW-1:0]  wr_ptr;
	logic   [PW:0]    level;

	// wrap a pointer at the queue depth
	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction : bump

	// storage, written only for whole frames
	always_ff @(posedge clk) begin
		if (q.push) begin
			mem[wr_ptr] <= q.push_entry;
		end
	end

	// pointers and fill level
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_ptr <= '0;
			wr_ptr <= '0;
			level  <= '0;
		end else begin
			if (q.push) begin
				wr_ptr <= bump(wr_ptr);
			end
			if (q.pop) begin
				rd_ptr <= bump(rd_ptr);
			end
			level <= level + (PW+1)'(q.push) - (PW+1)'(q.pop);
		end
	end

	assign q.head  = mem[rd_ptr];
	assign q.empty = (level == '0);
	assign q.full  = (level == (PW+1)'(DEPTH));
endmodule : rx_status_queue
`default_nettype wire

// ==== rtl/rx_frame_status_report.sv ====
/*
 receive frame status reporting: classifies each finished frame, keeps
 or discards it, queues its status and byte count, and mirrors the head
 entry in two read-only registers on a classic wishbone slave.
 assumes mac side inputs are synchronous to clk and that the frame
 attributes are stable in the cycle of rx_done.
*/
`timescale 1ns/100ps
`default_nettype none
module rx_frame_status_report #(
	parameter int DEPTH  = rx_status_pkg::QUEUE_DEPTH,
	parameter int ADDR_W = 8
) (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     rst_b,
	// wishbone slave
	input  wire logic                     wb_cyc_i,
	input  wire logic                     wb_stb_i,
	input  wire logic                     wb_we_i,
	input  wire logic [ADDR_W-1:0]        wb_adr_i,
	input  wire logic [3:0]               wb_sel_i,
	input  wire logic [31:0]              wb_dat_i,
	output var  logic [31:0]              wb_dat_o,
	output var  logic                     wb_ack_o,
	// mac receive side
	input  wire logic                     rx_active,
	input  wire logic                     rx_done,
	input  wire logic [47:0]              rx_dest_addr,
	input  wire logic [15:0]              rx_len_type,
	input  wire logic [rx_status_pkg::BYTE_COUNT_W-1:0] rx_byte_count,
	input  wire logic                     rx_symbol_err,
	input  wire logic                     rx_runt,
	input  wire logic                     rx_crc_err,
	// frame disposition to the packet memory
	output var  logic                     rx_keep,
	output var  logic                     rx_discard,
	output var  logic                     frame_pending
);
	import rx_status_pkg::*;

	// queue carrier
	rx_queue_if q ();

	// bus state
	bus_state_e bus_state;
	bus_state_e next_bus_state;

	// control state
	logic pass_bad;
	logic overflow;
	logic receiving;

	// capture stage between frame end and queue push
	logic   cap_valid;
	entry_s cap_entry;

	// head mirrors
	logic [STATUS_W-1:0]     status_mirror;
	logic [BYTE_COUNT_W-1:0] count_mirror;

	// decoded bus request
	logic       req;
	logic       wr_req;
	logic [5:0] idx;
	logic       bad_frame;
	logic       keep_frame;
	logic       pop_req;

	// one select line per register, from the index decode
	logic       sel_control;
	logic       sel_release;
	logic       sel_status;
	logic       sel_count;

	// control register write strobes and a frame lost to a full queue
	logic       ctrl_pass_wr;
	logic       ctrl_ovf_clr;
	logic       frame_lost;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------

	// compare a request address with a register index
	function automatic logic hit(
		input logic [5:0] a,
		input logic [5:0] i
	);
		hit = (a == i);
	endfunction : hit

	// build the status word for a finished frame
	function automatic logic [STATUS_W-1:0] frame_status(
		input logic [47:0]             da,
		input logic [15:0]             lt,
		input logic [BYTE_COUNT_W-1:0] n,
		input logic                    sym,
		input logic                    runt,
		input logic                    fcs
	);
		logic [STATUS_W-1:0] s;
		s = '0;
		// group bit is the first bit on the wire, lsb of octet 0
		s[BC_BIT]   = &da;
		s[MC_BIT]   = da[40];
		s[UC_BIT]   = ~da[40];
		s[SYM_BIT]  = sym;
		s[TYPE_BIT] = (lt > TYPE_THRESHOLD);
		s[LONG_BIT] = (n > MAX_FRAME_BYTES);
		s[RUNT_BIT] = runt;
		s[FCS_BIT]  = fcs;
		frame_status = s;
	endfunction : frame_status

	// byte enable for the lane that holds a given bit
	function automatic logic lane(
		input logic [3:0] sel,
		input int         bitpos
	);
		lane = sel[bitpos / 8];
	endfunction : lane

	// control register readback: pass-bad, queue full, overflow, busy
	function automatic logic [31:0] control_word(
		input logic pass,
		input logic full,
		input logic ovf,
		input logic busy
	);
		logic [31:0] w;
		w = '0;
		w[CTRL_PASS_BIT] = pass;
		w[CTRL_FULL_BIT] = full;
		w[CTRL_OVF_BIT]  = ovf;
		w[CTRL_BUSY_BIT] = busy;
		control_word = w;
	endfunction : control_word

	// ------------------------------------------------------------
	// frame status queue
	// ------------------------------------------------------------

	// completed frames wait here until software releases them
	rx_status_queue #(
		.DEPTH (DEPTH)
	) u_queue (
		.clk   (clk),
		.rst_b (rst_b),
		.q     (q.store)
	);

	// ------------------------------------------------------------
	// frame capture and disposition
	// ------------------------------------------------------------

	// a frame with the over-length, runt or check sequence flag set is bad
	// a symbol error alone does not make a frame bad
	assign bad_frame = cap_entry.status[LONG_BIT]
		| cap_entry.status[RUNT_BIT]
		| cap_entry.status[FCS_BIT];

	// bad frames survive only with pass-bad set
	assign keep_frame = ~bad_frame | pass_bad;

	// latch attributes at frame end; count kept whole, never clipped
	// the mac holds its attributes for the rx_done cycle only
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cap_valid <= 1'b0;
			cap_entry <= '0;
		end else begin
			cap_valid <= rx_done;
			if (rx_done) begin
				cap_entry.status <= frame_status(rx_dest_addr, rx_len_type,
					rx_byte_count, rx_symbol_err, rx_runt, rx_crc_err);
				cap_entry.count  <= rx_byte_count;
			end
		end
	end

	// only complete, accepted frames enter the queue
	assign q.push       = cap_valid & keep_frame & ~q.full;
	assign q.push_entry = cap_entry;
	assign frame_lost   = cap_valid & keep_frame & q.full;

	// disposition pulses to the packet memory
	// exactly one of keep or discard per finished frame, two cycles after rx_done
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_keep    <= 1'b0;
			rx_discard <= 1'b0;
		end else begin
			rx_keep    <= q.push;
			rx_discard <= cap_valid & ~q.push;
		end
	end

	// frame in flight, reported for software
	// only reported; the queue never holds a partial frame
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			receiving <= 1'b0;
		end else begin
			receiving <= rx_active;
		end
	end

	// ------------------------------------------------------------
	// head mirrors
	// ------------------------------------------------------------

	// valid only while a finished frame heads the queue
	// the mirrors trail the queue by one cycle; the master's idle cycle
	// after a release lets the next read see the new head already
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			status_mirror <= '0;
			count_mirror  <= '0;
			frame_pending <= 1'b0;
		end else if (q.empty) begin
			status_mirror <= '0;
			count_mirror  <= '0;
			frame_pending <= 1'b0;
		end else begin
			status_mirror <= q.head.status;
			status_mirror[FV_BIT] <= 1'b1;
			count_mirror  <= q.head.count;
			frame_pending <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// wishbone slave
	// ------------------------------------------------------------

	assign req    = wb_cyc_i & wb_stb_i & (bus_state == BUS_IDLE);
	assign wr_req = req & wb_we_i;
	assign idx    = wb_adr_i[7:2];

	// index decode; unmapped indices select nothing and read zero
	always_comb begin
		sel_control = 1'b0;
		sel_release = 1'b0;
		sel_status  = 1'b0;
		sel_count   = 1'b0;
		if (hit(idx, IDX_CONTROL)) begin
			sel_control = 1'b1;
		end else if (hit(idx, IDX_RELEASE)) begin
			sel_release = 1'b1;
		end else if (hit(idx, IDX_STATUS)) begin
			sel_status = 1'b1;
		end else if (hit(idx, IDX_BYTE_COUNT)) begin
			sel_count = 1'b1;
		end
	end

	// control writes: pass-bad follows bit 9, a one on bit 1 clears overflow
	assign ctrl_pass_wr = wr_req & sel_control & lane(wb_sel_i, CTRL_PASS_BIT);
	assign ctrl_ovf_clr = wr_req & sel_control & lane(wb_sel_i, CTRL_OVF_BIT)
		& wb_dat_i[CTRL_OVF_BIT];

	// release of the head frame by software; ignored on an empty queue
	assign pop_req = wr_req & sel_release
		& lane(wb_sel_i, RELEASE_POP_BIT)
		& wb_dat_i[RELEASE_POP_BIT] & ~q.empty;
	assign q.pop = pop_req;

	// handshake: one ack cycle, then one idle cycle
	// a request still held one cycle after its ack is taken again
	always_comb begin
		next_bus_state = bus_state;
		case (bus_state)
			BUS_IDLE: begin
				if (wb_cyc_i & wb_stb_i) begin
					next_bus_state = BUS_ACK;
				end
			end
			BUS_ACK: begin
				next_bus_state = BUS_IDLE;
			end
			default: begin
				next_bus_state = BUS_IDLE;
			end
		endcase
	end

	// handshake state register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bus_state <= BUS_IDLE;
		end else begin
			bus_state <= next_bus_state;
		end
	end

	// ack follows a taken request by one cycle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req;
		end
	end

	// read data; mirrors keep reserved bits at zero
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wb_dat_o <= '0;
		end else if (req) begin
			wb_dat_o <= '0;
			if (sel_status) begin
				wb_dat_o[STATUS_W-1:0] <= status_mirror;
			end else if (sel_count) begin
				wb_dat_o[BYTE_COUNT_W-1:0] <= count_mirror;
			end else if (sel_control) begin
				wb_dat_o <= control_word(pass_bad, q.full, overflow, receiving);
			end
		end
	end

	// pass-bad control; writes to the mirrors fall through here unused
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pass_bad <= PASS_BAD_RESET;
		end else if (ctrl_pass_wr) begin
			pass_bad <= wb_dat_i[CTRL_PASS_BIT];
		end
	end

	// sticky queue overflow, write one to clear; a new loss wins
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			overflow <= 1'b0;
		end else if (frame_lost) begin
			overflow <= 1'b1;
		end else if (ctrl_ovf_clr) begin
			overflow <= 1'b0;
		end
	end

endmodule : rx_frame_status_report
`default_nettype wire

// ==== testbench/rx_status_properties.sv ====
/* checker for the status reporter: bus answer and frame disposition timing.
   assumes the bus master drops stb after every ack. */
`timescale 1ns/100ps
`default_nettype none
module rx_status_properties #(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input wire logic              clk,
	input wire logic              rst_b,
	// wishbone
	input wire logic              wb_cyc_i,
	input wire logic              wb_stb_i,
	input wire logic              wb_we_i,
	input wire logic [ADDR_W-1:0] wb_adr_i,
	input wire logic [31:0]       wb_dat_o,
	input wire logic              wb_ack_o,
	// frame side
	input wire logic              rx_done,
	input wire logic              rx_keep,
	input wire logic              rx_discard,
	input wire logic              frame_pending
);
	import rx_status_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// answer cycle of a read of either mirror
	logic rd_st;
	logic rd_bc;
	assign rd_st = wb_ack_o && !wb_we_i && wb_adr_i[7:2] == IDX_STATUS;
	assign rd_bc = wb_ack_o && !wb_we_i && wb_adr_i[7:2] == IDX_BYTE_COUNT;

	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("no ack one cycle after a request");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_disp_timing: assert property (rx_done |-> ##2 (rx_keep || rx_discard))
		else $error("no disposition two cycles after frame end");
	a_disp_cause: assert property ((rx_keep || rx_discard) |->
		$past(rx_done, 2) && !(rx_keep && rx_discard))
		else $error("disposition without frame end");
	a_pending_rise: assert property ($rose(frame_pending) |-> $past(rx_keep))
		else $error("frame pending without a kept frame");
	a_pending_keep: assert property (rx_keep && !frame_pending |=> frame_pending)
		else $error("kept frame not pending");
	a_valid_mirror: assert property (rd_st |-> wb_dat_o[15] == $past(frame_pending))
		else $error("valid bit differs from pending");
	a_status_rsvd: assert property (rd_st |-> wb_dat_o[31:16] == 16'h0000 &&
		wb_dat_o[14:8] == 7'h00)
		else $error("status reserved bits set");
	a_count_rsvd: assert property (rd_bc |-> wb_dat_o[31:11] == 21'h00000 &&
		($past(frame_pending) || wb_dat_o == 32'h0))
		else $error("byte count upper bits set");
	a_dest_class: assert property (rd_st && wb_dat_o[15] |->
		wb_dat_o[5] != wb_dat_o[6] && (!wb_dat_o[7] || wb_dat_o[6]))
		else $error("address class bits inconsistent");

	c_keep: cover property (rx_keep);
	c_discard: cover property (rx_discard);
	c_status_rd: cover property (rd_st && wb_dat_o[15]);
endmodule : rx_status_properties
`default_nettype wire

bind rx_frame_status_report rx_status_properties #(.ADDR_W(ADDR_W)) chk (
	.clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.rx_done(rx_done), .rx_keep(rx_keep), .rx_discard(rx_discard),
	.frame_pending(frame_pending));

// ==== testbench/rx_host_model.sv ====
/* host processor model: classic wishbone master reading frame status.
   assumes the slave answers with a registered ack. */
`timescale 1ns/100ps
`default_nettype none
module rx_host_model (
	// clock
	input wire logic        clk,
	// wishbone master
	output var logic        cyc,
	output var logic        stb,
	output var logic        we,
	output var logic [7:0]  adr,
	output var logic [3:0]  sel,
	output var logic [31:0] dat,
	input wire logic [31:0] dat_in,
	input wire logic        ack
);
	// bus idle from time zero
	initial begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'h0;
		dat = 32'h0;
	end

	// one cycle: hold until ack is sampled high, take data and release at that edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hf;
		dat <= d;
		do
			@(posedge clk);
		while (ack !== 1'b1);
		q = dat_in;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : xfer

	// host view: the type bit means nothing on a short frame
	function automatic logic [31:0] seen(input logic [31:0] s);
		return s[1] ? (s & ~32'h8) : s;
	endfunction : seen
endmodule : rx_host_model
`default_nettype wire

// ==== testbench/testbench.sv ====
/* self-checking bench for the receive frame status reporter.
   assumes the host model drives the register bus. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import rx_status_pkg::*;
	logic        clk = 1'b0;
	logic        rst_b;
	logic        rx_active, rx_done, sym, rn, fc;
	logic [47:0] da;
	logic [15:0] lt;
	logic [10:0] cnt;
	logic        cyc, stb, we, ack, keep, disc, pend;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] dat_w, dat_r, q;
	int          n_fail = 0;
	int          n_checks = 0;
	int          cycles = 0;

	always #4 clk = ~clk;

	rx_frame_status_report dut (
		.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
		.wb_ack_o(ack), .rx_active(rx_active), .rx_done(rx_done), .rx_dest_addr(da),
		.rx_len_type(lt), .rx_byte_count(cnt), .rx_symbol_err(sym), .rx_runt(rn),
		.rx_crc_err(fc), .rx_keep(keep), .rx_discard(disc), .frame_pending(pend));
	rx_host_model host (
		.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
		.dat(dat_w), .dat_in(dat_r), .ack(ack));

	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : finish_test

	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			finish_test;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// expected status word of a kept frame
	function automatic logic [31:0] st(input logic [47:0] a, input logic [15:0] l,
		input logic [10:0] n, input logic [2:0] e);
		return {16'h0, 1'b1, 7'h0, &a, a[40], ~a[40], e[2], l > 16'h05dc, n > 11'h77c, e[1:0]};
	endfunction : st

	// one finished frame; compares keep and discard pulses
	task automatic frame(input logic [47:0] a, input logic [15:0] l, input logic [10:0] n,
		input logic [2:0] e, input logic k);
		@(posedge clk);
		rx_done <= 1'b1;
		da <= a;
		lt <= l;
		cnt <= n;
		{sym, rn, fc} <= e;
		@(posedge clk);
		rx_done <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		chk({30'h0, keep, disc}, {30'h0, k, ~k});
	endtask : frame

	// kept frame: check both mirrors, then release it
	task automatic pass(input logic [47:0] a, input logic [15:0] l, input logic [10:0] n,
		input logic [2:0] e);
		frame(a, l, n, e, 1'b1);
		@(negedge clk);
		chk({31'h0, pend}, 32'h1);
		host.xfer(1'b0, 8'h10, 32'h0, q);
		chk(host.seen(q), host.seen(st(a, l, n, e)));
		host.xfer(1'b0, 8'h18, 32'h0, q);
		chk(q, {21'h0, n});
		host.xfer(1'b1, 8'h04, 32'h1, q);
		@(negedge clk);
		chk({31'h0, pend}, 32'h0);
	endtask : pass

	task automatic t_idle;
		rx_active <= 1'b1;
		host.xfer(1'b1, 8'h10, 32'hffffffff, q);
		host.xfer(1'b0, 8'h10, 32'h0, q);
		chk(q, 32'h0);
		host.xfer(1'b1, 8'h18, 32'hffffffff, q);
		host.xfer(1'b0, 8'h18, 32'h0, q);
		chk(q, 32'h0);
		host.xfer(1'b0, 8'h3c, 32'h0, q);
		chk(q, 32'h0);
		rx_active <= 1'b0;
	endtask : t_idle

	task automatic t_classes;
		pass(48'hffffffffffff, 16'h05dd, 11'h040, 3'b000);
		pass(48'h01005e000001, 16'h05dc, 11'h5dc, 3'b100);
		pass(48'h00a0c9000001, 16'h0800, 11'h77c, 3'b000);
	endtask : t_classes

	// two frames queued back to back; head first, then the next
	task automatic t_queue;
		frame(48'h00a0c9000002, 16'h0800, 11'h100, 3'b000, 1'b1);
		frame(48'hffffffffffff, 16'h0010, 11'h200, 3'b100, 1'b1);
		host.xfer(1'b0, 8'h10, 32'h0, q);
		chk(q, st(48'h00a0c9000002, 16'h0800, 11'h100, 3'b000));
		host.xfer(1'b1, 8'h04, 32'h1, q);
		host.xfer(1'b0, 8'h18, 32'h0, q);
		chk(q, 32'h200);
		host.xfer(1'b1, 8'h04, 32'h1, q);
	endtask : t_queue

	// bad frames dropped unless pass-bad is set, then kept whole
	task automatic t_bad;
		frame(48'h00a0c9000003, 16'h0800, 11'h030, 3'b010, 1'b0);
		frame(48'h00a0c9000003, 16'h0800, 11'h100, 3'b001, 1'b0);
		frame(48'h00a0c9000003, 16'h0800, 11'h77d, 3'b000, 1'b0);
		chk({31'h0, pend}, 32'h0);
		host.xfer(1'b1, 8'h00, 32'h200, q);
		pass(48'h00a0c9000003, 16'h0800, 11'h7ff, 3'b000);
		pass(48'h00a0c9000003, 16'h0800, 11'h030, 3'b010);
		pass(48'h00a0c9000003, 16'h0800, 11'h100, 3'b001);
		host.xfer(1'b1, 8'h00, 32'h0, q);
	endtask : t_bad

	// queue filled to depth: the next frame is lost and flagged in control
	task automatic t_full;
		repeat (QUEUE_DEPTH) frame(48'h00a0c9000004, 16'h0800, 11'h080, 3'b000, 1'b1);
		frame(48'h00a0c9000004, 16'h0800, 11'h081, 3'b000, 1'b0);
		host.xfer(1'b0, 8'h00, 32'h0, q);
		chk(q, 32'h3);
		rx_active <= 1'b1;
		host.xfer(1'b1, 8'h00, 32'h2, q);
		host.xfer(1'b0, 8'h00, 32'h0, q);
		chk(q, 32'h5);
		rx_active <= 1'b0;
		repeat (QUEUE_DEPTH) host.xfer(1'b1, 8'h04, 32'h1, q);
		host.xfer(1'b0, 8'h00, 32'h0, q);
		chk(q, 32'h0);
		chk({31'h0, pend}, 32'h0);
	endtask : t_full

	initial begin
		rst_b = 1'b0;
		rx_active = 1'b0;
		rx_done = 1'b0;
		{sym, rn, fc} = 3'b000;
		da = 48'h0;
		lt = 16'h0;
		cnt = 11'h0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		t_idle;
		t_classes;
		t_queue;
		t_bad;
		t_full;
		finish_test;
	end
endmodule : testbench
`default_nettype wire
